//--- hdl/riv_pkg.sv
/*
  Constants for the reset and interrupt vectoring block: machine-cycle timing,
  reset values, flag and source positions, and the vector address function.
  Assumes a single oscillator clock with a 12-clock machine cycle.
*/
package riv_pkg;

  // Machine cycle: 12 clocks, counted 0 to 11
  localparam logic [3:0] MC_LAST = 4'hB;
  // State 5 phase 2 is clock 9 of the machine cycle
  localparam logic [3:0] SAMPLE_POINT = 4'h9;
  // Machine cycles the core reset lasts after its cause ends
  localparam logic [1:0] RST_STRETCH_MC = 2'h2;
  // Clock count after reset release at which the boot strap is taken
  localparam logic [1:0] STRAP_CAPTURE = 2'h2;

  // Values loaded while the core is held in reset
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [7:0] CHIP_CTRL_RESET = 8'h00;
  localparam logic [9:0] FLAGS_RESET = 10'h000;
  localparam logic [8:0] IRQ_EN_RESET = 9'h000;
  localparam logic [1:0] EDGE_SEL_RESET = 2'h0;
  localparam logic [3:0] EXT_IDLE = 4'hF;
  localparam logic [1:0] WDT_SEL_RESET = 2'h0;

  // Chip control bits 0, 1 and 7 together request a software reset
  localparam logic [7:0] SWRST_MASK = 8'h83;

  // Global enable position in the enable word
  localparam int IRQ_EN_GLOBAL = 8;

  // Flag positions in the flag word
  localparam int F_EXT0 = 0;
  localparam int F_TMR0 = 1;
  localparam int F_EXT1 = 2;
  localparam int F_TMR1 = 3;
  localparam int F_RX = 4;
  localparam int F_TX = 5;
  localparam int F_TMR2_OVF = 6;
  localparam int F_TMR2_EXT = 7;
  localparam int F_EXT2 = 8;
  localparam int F_EXT3 = 9;

  // Source numbers, which also order the vector table
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_TMR0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_TMR1 = 3'h3;

  // Watchdog counter width in bits; the count is in machine cycles
  localparam int WDT_CNT_W = 18;

  // Vector low bits; vectors sit eight bytes apart from 0003h
  localparam logic [2:0] VEC_LOW = 3'h3;

  // Vector address of a source
  function automatic logic [15:0] riv_vec_addr(input logic [2:0] src);
    riv_vec_addr = {10'h000, src, VEC_LOW};
  endfunction : riv_vec_addr

endpackage : riv_pkg

//--- hdl/riv_wdt.sv
/*
  Watchdog counter: counts machine cycles while running and pulses on time-out.
  Assumes tick_i is a one-clock pulse once per machine cycle on clk_i.
*/
`timescale 1ns/100ps
module riv_wdt #(
  parameter int BASE_MC = 16384
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic clear_i,
  input wire logic [1:0] sel_i,
  // Time-out pulse
  output logic timeout_o
);

  // Count of machine cycles
  logic [riv_pkg::WDT_CNT_W-1:0] cnt_reg;
  // Interval in machine cycles, base times 1, 2, 4 or 8
  logic [riv_pkg::WDT_CNT_W-1:0] limit;

  // Interval chosen by the select bits
  always_comb begin
    limit = riv_pkg::WDT_CNT_W'(BASE_MC) << sel_i;
  end

  // Free running count, restarted by a clear or a stop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (clear_i || !run_i) begin
        cnt_reg <= '0;
      end else if (tick_i) begin
        if (cnt_reg == limit - riv_pkg::WDT_CNT_W'(1)) begin
          cnt_reg <= '0;
          timeout_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + riv_pkg::WDT_CNT_W'(1);
        end
      end
    end
  end

endmodule : riv_wdt

//--- hdl/riv_reset_irq.sv
/*
  Reset sequencing and interrupt request flags with vectoring for an
  8051-class core. Assumes timer and serial events arrive as one-clock pulses
  on CLK_I, and that the core acknowledges one source at a time.
*/
// How it works
// - Reset pin sampled at state 5 phase 2
// - Internal reset is applied on the clock
// - Reset holds two machine cycles, no flag
// - Control bits 0, 1, 7 restart core
// - Software restart only from loader to application
// - Watchdog runs, restarts on clear, flags time-out
// - Watchdog reset holds core two machine cycles
// - Program counter held at 0000h in reset
// - Reset keeps RAM, stack pointer becomes 07h
// - Reset clears enables, ports load 0FFh
// - Only power-on reset disables the watchdog
// - External 0 and 1 edge or level
// - Edge: high sample then low sets flag
// - Edge flag cleared when vectoring
// - Level flag follows pin, not cleared
// - Timer 0 and 1 flags cleared on vectoring
// - Timer 2 requests on either flag, software clears
// - Serial and external 2, 3 flags software cleared
// - Flags writable, per-source and global enables
// - Vectors 0003h upward in steps of eight
`timescale 1ns/100ps
module riv_reset_irq #(
  parameter int WDT_BASE_MC = 16384
) (
  // Clock and power-on reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Pins from outside
  input wire logic EXT_RESET_PIN_I,
  input wire logic BOOT_LOADER_STRAP_I,
  input wire logic EXT0_REQUEST_PIN_I,
  input wire logic EXT1_REQUEST_PIN_I,
  input wire logic EXT2_REQUEST_PIN_I,
  input wire logic EXT3_REQUEST_PIN_I,
  // Event pulses from timers and serial block
  input wire logic TMR0_OVERFLOW_I,
  input wire logic TMR1_OVERFLOW_I,
  input wire logic TMR2_OVERFLOW_I,
  input wire logic TMR2_EXTERNAL_FLAG_I,
  input wire logic RX_DONE_FLAG_I,
  input wire logic TX_DONE_FLAG_I,
  // Flag word access
  input wire logic FLAG_WE_I,
  input wire logic [9:0] FLAG_WDATA_I,
  output logic [9:0] FLAGS_O,
  // External request mode selects
  input wire logic EXT_MODE_WE_I,
  input wire logic EXT0_EDGE_SELECT_I,
  input wire logic EXT1_EDGE_SELECT_I,
  // Enables and requests
  input wire logic IRQ_ENABLE_WE_I,
  input wire logic [8:0] IRQ_ENABLE_WDATA_I,
  output logic [8:0] IRQ_ENABLE_O,
  output logic [7:0] IRQ_REQ_O,
  // Vectoring acknowledge from the core
  input wire logic VEC_ACK_I,
  input wire logic [2:0] VEC_SRC_I,
  // Chip control
  input wire logic CHIP_CONTROL_WE_I,
  input wire logic [7:0] CHIP_CONTROL_WDATA_I,
  output logic [7:0] CHIP_CONTROL_O,
  // Watchdog control and status
  input wire logic WDT_CTRL_WE_I,
  input wire logic WDT_RUN_I,
  input wire logic WDT_RESET_EN_I,
  input wire logic [1:0] WDT_SEL_I,
  input wire logic WDT_CLEAR_I,
  input wire logic WDT_FLAG_CLR_I,
  output logic WDT_FLAG_O,
  // Core reset state
  output logic CORE_RST_O,
  output logic PC_LOAD_O,
  output logic [15:0] PC_VALUE_O,
  output logic [7:0] SP_VALUE_O,
  output logic [7:0] PORT_VALUE_O,
  output logic APP_STORE_O
);

  // Saturation value of the clocks-since-release count
  localparam logic [1:0] STRAP_MAX = 2'h3;
  logic [3:0] mc_cnt_reg; // Clock within machine cycle
  logic mc_tick; // State 5 phase 2 pulse
  logic rst_meta_reg; // Reset pin first stage
  logic rst_sync_reg; // Reset pin second stage
  logic strap_meta_reg; // Strap first stage
  logic strap_sync_reg; // Strap second stage
  logic [1:0] strap_cnt_reg; // Clocks since release
  logic [3:0] ext_meta_reg; // Request pins first stage
  logic [3:0] ext_sync_reg; // Request pins second stage
  logic [3:0] ext_samp_reg; // Last machine-cycle sample
  logic [3:0] ext_fall; // High then low between samples
  logic [1:0] stretch_reg; // Machine cycles of reset left
  logic sw_rst_req; // Accepted software restart
  logic wdt_rst_req; // Watchdog reset request
  logic wdt_timeout; // Watchdog time-out pulse
  logic wdt_run_reg; // Watchdog running
  logic wdt_rst_en_reg; // Watchdog may reset
  logic [1:0] wdt_sel_reg; // Watchdog interval select
  logic [7:0] chip_control_reg; // Chip control value
  logic [1:0] ext_edge_select_reg; // Edge selects, ext 1 and 0
  logic [8:0] irq_enable_reg; // Source enables and global
  logic [9:0] flags_reg; // Request flags
  logic [9:0] flags_next; // Next request flags
  logic [9:0] hw_set; // Hardware flag sets
  logic [7:0] src_req; // Per-source raw requests
  logic ack_ok; // Acknowledge outside reset
  logic global_irq_enable; // Global enable bit

  assign FLAGS_O = flags_reg;
  assign IRQ_ENABLE_O = irq_enable_reg;
  assign CHIP_CONTROL_O = chip_control_reg;
  assign global_irq_enable = irq_enable_reg[riv_pkg::IRQ_EN_GLOBAL];
  assign ack_ok = VEC_ACK_I && !CORE_RST_O;

  assign mc_tick = (mc_cnt_reg == riv_pkg::SAMPLE_POINT);

  // Machine cycle counter
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mc_cnt_reg <= 4'h0;
    end else if (mc_cnt_reg == riv_pkg::MC_LAST) begin
      mc_cnt_reg <= 4'h0;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + 4'h1;
    end
  end

  // Two-stage synchronisers for all pins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
      ext_meta_reg <= riv_pkg::EXT_IDLE;
      ext_sync_reg <= riv_pkg::EXT_IDLE;
    end else begin
      rst_meta_reg <= EXT_RESET_PIN_I;
      rst_sync_reg <= rst_meta_reg;
      strap_meta_reg <= BOOT_LOADER_STRAP_I;
      strap_sync_reg <= strap_meta_reg;
      ext_meta_reg <= {EXT3_REQUEST_PIN_I, EXT2_REQUEST_PIN_I,
                       EXT1_REQUEST_PIN_I, EXT0_REQUEST_PIN_I};
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // Boot store: strap taken shortly after release, software restart to app
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      strap_cnt_reg <= 2'h0;
      APP_STORE_O <= 1'b1;
    end else begin
      if (strap_cnt_reg != STRAP_MAX) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_cnt_reg == riv_pkg::STRAP_CAPTURE) begin
        APP_STORE_O <= !strap_sync_reg;
      end else if (sw_rst_req) begin
        APP_STORE_O <= 1'b1;
      end
    end
  end

  assign sw_rst_req = CHIP_CONTROL_WE_I && !CORE_RST_O && !APP_STORE_O
                      && ((CHIP_CONTROL_WDATA_I & riv_pkg::SWRST_MASK)
                          == riv_pkg::SWRST_MASK);

  // Chip control register, cleared by any core reset
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      chip_control_reg <= riv_pkg::CHIP_CTRL_RESET;
    end else if (CORE_RST_O || sw_rst_req) begin
      chip_control_reg <= riv_pkg::CHIP_CTRL_RESET;
    end else if (CHIP_CONTROL_WE_I) begin
      chip_control_reg <= CHIP_CONTROL_WDATA_I;
    end
  end

  // watchdog settings cleared by power-on only
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wdt_run_reg <= 1'b0;
      wdt_rst_en_reg <= 1'b0;
      wdt_sel_reg <= riv_pkg::WDT_SEL_RESET;
    end else if (WDT_CTRL_WE_I) begin
      wdt_run_reg <= WDT_RUN_I;
      wdt_rst_en_reg <= WDT_RESET_EN_I;
      wdt_sel_reg <= WDT_SEL_I;
    end
  end

  // Watchdog counter
  riv_wdt #(
    .BASE_MC(WDT_BASE_MC)
  ) u_wdt (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .tick_i(mc_tick),
    .run_i(wdt_run_reg),
    .clear_i(WDT_CLEAR_I),
    .sel_i(wdt_sel_reg),
    .timeout_o(wdt_timeout)
  );

  // time-out flag, set wins over clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      WDT_FLAG_O <= 1'b0;
    end else if (wdt_timeout) begin
      WDT_FLAG_O <= 1'b1;
    end else if (WDT_FLAG_CLR_I) begin
      WDT_FLAG_O <= 1'b0;
    end
  end

  assign wdt_rst_req = wdt_timeout && wdt_rst_en_reg;

  // Core reset sequencer, counting machine cycles of stretch
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CORE_RST_O <= 1'b1;
      stretch_reg <= riv_pkg::RST_STRETCH_MC;
    end else if (mc_tick && rst_sync_reg) begin
      CORE_RST_O <= 1'b1;
      stretch_reg <= riv_pkg::RST_STRETCH_MC;
    end else if (wdt_rst_req || sw_rst_req) begin
      CORE_RST_O <= 1'b1;
      stretch_reg <= riv_pkg::RST_STRETCH_MC;
    end else if (CORE_RST_O && mc_tick) begin
      if (stretch_reg <= 2'h1) begin
        CORE_RST_O <= 1'b0;
        stretch_reg <= 2'h0;
      end else begin
        stretch_reg <= stretch_reg - 2'h1;
      end
    end
  end

  // Program counter, stack pointer and port values for the core
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PC_LOAD_O <= 1'b1;
      PC_VALUE_O <= riv_pkg::PC_RESET;
      SP_VALUE_O <= riv_pkg::SP_RESET;
      PORT_VALUE_O <= riv_pkg::PORT_RESET;
    end else if (CORE_RST_O) begin
      PC_LOAD_O <= 1'b1;
      PC_VALUE_O <= riv_pkg::PC_RESET;
      SP_VALUE_O <= riv_pkg::SP_RESET;
      PORT_VALUE_O <= riv_pkg::PORT_RESET;
    end else if (ack_ok) begin
      PC_LOAD_O <= 1'b1;
      PC_VALUE_O <= riv_pkg::riv_vec_addr(VEC_SRC_I);
    end else begin
      PC_LOAD_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_enable_reg <= riv_pkg::IRQ_EN_RESET;
      ext_edge_select_reg <= riv_pkg::EDGE_SEL_RESET;
    end else if (CORE_RST_O) begin
      irq_enable_reg <= riv_pkg::IRQ_EN_RESET;
      ext_edge_select_reg <= riv_pkg::EDGE_SEL_RESET;
    end else begin
      if (IRQ_ENABLE_WE_I) begin
        irq_enable_reg <= IRQ_ENABLE_WDATA_I;
      end
      if (EXT_MODE_WE_I) begin
        ext_edge_select_reg <= {EXT1_EDGE_SELECT_I, EXT0_EDGE_SELECT_I};
      end
    end
  end

  // Once-per-machine-cycle sample of the request pins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ext_samp_reg <= riv_pkg::EXT_IDLE;
    end else if (mc_tick) begin
      ext_samp_reg <= ext_sync_reg;
    end
  end

  assign ext_fall = ext_samp_reg & ~ext_sync_reg;

  // Hardware set terms
  always_comb begin
    hw_set = '0;
    hw_set[riv_pkg::F_EXT0] = mc_tick && ext_edge_select_reg[0] && ext_fall[0];
    hw_set[riv_pkg::F_EXT1] = mc_tick && ext_edge_select_reg[1] && ext_fall[1];
    hw_set[riv_pkg::F_EXT2] = mc_tick && ext_fall[2];
    hw_set[riv_pkg::F_EXT3] = mc_tick && ext_fall[3];
    hw_set[riv_pkg::F_TMR0] = TMR0_OVERFLOW_I;
    hw_set[riv_pkg::F_TMR1] = TMR1_OVERFLOW_I;
    hw_set[riv_pkg::F_TMR2_OVF] = TMR2_OVERFLOW_I;
    hw_set[riv_pkg::F_TMR2_EXT] = TMR2_EXTERNAL_FLAG_I;
    hw_set[riv_pkg::F_RX] = RX_DONE_FLAG_I;
    hw_set[riv_pkg::F_TX] = TX_DONE_FLAG_I;
  end

  // Next flags: level follow, software write, vector clear, then sets
  always_comb begin
    flags_next = flags_reg;
    if (mc_tick) begin
      if (!ext_edge_select_reg[0]) begin
        flags_next[riv_pkg::F_EXT0] = !ext_sync_reg[0];
      end
      if (!ext_edge_select_reg[1]) begin
        flags_next[riv_pkg::F_EXT1] = !ext_sync_reg[1];
      end
    end
    if (FLAG_WE_I) begin
      flags_next = FLAG_WDATA_I;
    end
    if (ack_ok) begin
      case (VEC_SRC_I)
        riv_pkg::SRC_EXT0: begin
          if (ext_edge_select_reg[0]) flags_next[riv_pkg::F_EXT0] = 1'b0;
        end
        riv_pkg::SRC_EXT1: begin
          if (ext_edge_select_reg[1]) flags_next[riv_pkg::F_EXT1] = 1'b0;
        end
        riv_pkg::SRC_TMR0: flags_next[riv_pkg::F_TMR0] = 1'b0;
        riv_pkg::SRC_TMR1: flags_next[riv_pkg::F_TMR1] = 1'b0;
        default: ;
      endcase
    end
    // Events win over any clear
    flags_next = flags_next | hw_set;
  end

  // Flag register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flags_reg <= riv_pkg::FLAGS_RESET;
    end else if (CORE_RST_O) begin
      flags_reg <= riv_pkg::FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // timer 2 ORs its flags; serial ORs its flags
  assign src_req = {flags_reg[riv_pkg::F_EXT3], flags_reg[riv_pkg::F_EXT2],
                    flags_reg[riv_pkg::F_TMR2_OVF] | flags_reg[riv_pkg::F_TMR2_EXT],
                    flags_reg[riv_pkg::F_RX] | flags_reg[riv_pkg::F_TX],
                    flags_reg[riv_pkg::F_TMR1], flags_reg[riv_pkg::F_EXT1],
                    flags_reg[riv_pkg::F_TMR0], flags_reg[riv_pkg::F_EXT0]};

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      IRQ_REQ_O <= 8'h00;
    end else if (CORE_RST_O) begin
      IRQ_REQ_O <= 8'h00;
    end else begin
      IRQ_REQ_O <= src_req & irq_enable_reg[7:0] & {8{global_irq_enable}};
    end
  end

  // Checks
  tick_spacing_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    mc_tick |-> ##12 mc_tick) else $error("sample tick spacing wrong");
  pin_reset_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (mc_tick && rst_sync_reg) |=> CORE_RST_O [*8]) else $error("pin reset not held");
  release_stretch_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(CORE_RST_O) |-> $past(mc_tick) && !$past(rst_sync_reg, 12))
    else $error("reset released off tick or early");
  soft_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    sw_rst_req |=> CORE_RST_O && APP_STORE_O) else $error("software reset missing");
  app_no_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (APP_STORE_O && strap_cnt_reg == STRAP_MAX) |=> APP_STORE_O)
    else $error("left application store");
  wdt_reset_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    wdt_rst_req |=> CORE_RST_O [*8]) else $error("watchdog reset too short");
  pc_held_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    CORE_RST_O [*2] |-> PC_LOAD_O && PC_VALUE_O == riv_pkg::PC_RESET)
    else $error("pc not held at zero");
  reset_state_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(CORE_RST_O) |-> irq_enable_reg == riv_pkg::IRQ_EN_RESET
      && SP_VALUE_O == riv_pkg::SP_RESET && PORT_VALUE_O == riv_pkg::PORT_RESET)
    else $error("reset state wrong");
  wdt_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (CORE_RST_O && !WDT_CTRL_WE_I) |=> $stable(wdt_run_reg))
    else $error("core reset touched watchdog");
  edge_set_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!CORE_RST_O && hw_set[riv_pkg::F_EXT0]) |=> flags_reg[riv_pkg::F_EXT0])
    else $error("edge not flagged");
  edge_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (ack_ok && VEC_SRC_I == riv_pkg::SRC_EXT0 && ext_edge_select_reg[0]
      && !hw_set[riv_pkg::F_EXT0]) |=> !flags_reg[riv_pkg::F_EXT0])
    else $error("edge flag not cleared");
  level_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (ack_ok && VEC_SRC_I == riv_pkg::SRC_EXT1 && !ext_edge_select_reg[1] && !mc_tick
      && !FLAG_WE_I && flags_reg[riv_pkg::F_EXT1]) |=> flags_reg[riv_pkg::F_EXT1])
    else $error("level flag cleared on vectoring");
  tmr_clear_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (ack_ok && VEC_SRC_I == riv_pkg::SRC_TMR0 && !TMR0_OVERFLOW_I)
      |=> !flags_reg[riv_pkg::F_TMR0]) else $error("timer flag not cleared");
  serial_keep_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (ack_ok && !FLAG_WE_I && flags_reg[riv_pkg::F_RX]) |=> flags_reg[riv_pkg::F_RX])
    else $error("serial flag cleared by hardware");
  req_mask_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CORE_RST_O |=> IRQ_REQ_O == ($past(src_req) & $past(irq_enable_reg[7:0])
      & {8{$past(global_irq_enable)}})) else $error("request mask wrong");
  vector_addr_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    ack_ok |=> PC_LOAD_O && PC_VALUE_O == riv_pkg::riv_vec_addr($past(VEC_SRC_I)))
    else $error("vector address wrong");

  ext_vector_c: cover property (@(posedge CLK_I) disable iff (RST_I)
    IRQ_REQ_O[0] ##[1:20] ack_ok);
  wdt_reset_c: cover property (@(posedge CLK_I) disable iff (RST_I) wdt_rst_req);
  soft_reset_c: cover property (@(posedge CLK_I) disable iff (RST_I) sw_rst_req);
  pin_reset_c: cover property (@(posedge CLK_I) disable iff (RST_I)
    mc_tick && rst_sync_reg);

endmodule : riv_reset_irq

//--- verif/riv_ext_model.sv
/*
  Far-side model: external reset circuit and the four request devices.
  Assumes the bench asks for a reset burst or a pin level after a clock edge.
*/
`timescale 1ns/100ps
module riv_ext_model (
  // Clock and bench commands
  input wire logic clk_i,
  input wire logic rst_go_i,
  input wire logic [3:0] req_low_i,
  // Pins into the block
  output logic rst_pin_o,
  output logic [3:0] req_pin_o
);
  int rcnt = 0; // Reset burst clocks left
  int hcnt = 0; // Clocks a pin level must still stand
  initial req_pin_o = 4'hF;
  assign rst_pin_o = (rcnt > 0);
  // Burst counter and request pin levels
  always @(posedge clk_i) begin
    if (rst_go_i) rcnt <= 30;
    else if (rcnt > 0) rcnt <= rcnt - 1;
    if (hcnt > 0) hcnt <= hcnt - 1;
    else if (req_pin_o != ~req_low_i) begin
      req_pin_o <= ~req_low_i;
      hcnt <= 13;
    end
  end
endmodule : riv_ext_model

//--- verif/test_riv_reset_irq.sv
/*
  Self-checking bench for the reset and vectoring block.
  Assumes a watchdog base of 4 machine cycles to keep time-outs short.
*/
`timescale 1ns/100ps
module test_riv_reset_irq;
  logic clk = 0, rst = 1, strap = 1, go = 0, fwe = 0, mwe = 0, e0 = 0, e1 = 0;
  logic ewe = 0, ack_v = 0, cwe = 0, wwe = 0, wrun = 0, wren = 0, wclr = 0, wfc = 0;
  logic rpin;
  logic [3:0] rq = '0, pins;
  logic [5:0] ev = '0;
  logic [9:0] fwd = '0, flags;
  logic [8:0] ewd = '0, en;
  logic [7:0] req, cwd = '0, cc, sp, port;
  logic [2:0] src = '0;
  logic [1:0] wsel = '0;
  logic [15:0] pc;
  logic core_rst, pc_load, app, wflag;
  int err_total = 0, comparisons = 0;
  always #25 clk = ~clk;
  riv_ext_model ext_u (.clk_i(clk), .rst_go_i(go), .req_low_i(rq), .rst_pin_o(rpin),
    .req_pin_o(pins));
  riv_reset_irq #(.WDT_BASE_MC(4)) dut_u (.CLK_I(clk), .RST_I(rst), .EXT_RESET_PIN_I(rpin),
    .BOOT_LOADER_STRAP_I(strap), .EXT0_REQUEST_PIN_I(pins[0]), .EXT1_REQUEST_PIN_I(pins[1]),
    .EXT2_REQUEST_PIN_I(pins[2]), .EXT3_REQUEST_PIN_I(pins[3]), .TMR0_OVERFLOW_I(ev[0]),
    .TMR1_OVERFLOW_I(ev[1]), .TMR2_OVERFLOW_I(ev[2]), .TMR2_EXTERNAL_FLAG_I(ev[3]),
    .RX_DONE_FLAG_I(ev[4]), .TX_DONE_FLAG_I(ev[5]), .FLAG_WE_I(fwe), .FLAG_WDATA_I(fwd),
    .FLAGS_O(flags), .EXT_MODE_WE_I(mwe), .EXT0_EDGE_SELECT_I(e0), .EXT1_EDGE_SELECT_I(e1),
    .IRQ_ENABLE_WE_I(ewe), .IRQ_ENABLE_WDATA_I(ewd), .IRQ_ENABLE_O(en), .IRQ_REQ_O(req),
    .VEC_ACK_I(ack_v), .VEC_SRC_I(src), .CHIP_CONTROL_WE_I(cwe), .CHIP_CONTROL_WDATA_I(cwd),
    .CHIP_CONTROL_O(cc), .WDT_CTRL_WE_I(wwe), .WDT_RUN_I(wrun), .WDT_RESET_EN_I(wren),
    .WDT_SEL_I(wsel), .WDT_CLEAR_I(wclr), .WDT_FLAG_CLR_I(wfc), .WDT_FLAG_O(wflag),
    .CORE_RST_O(core_rst), .PC_LOAD_O(pc_load), .PC_VALUE_O(pc), .SP_VALUE_O(sp),
    .PORT_VALUE_O(port), .APP_STORE_O(app));
  // Step n clocks, landing just after the edge
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  // Compare and count
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Bounded wait for core reset level
  task wrst(input logic v);
    for (int i = 0; i < 200 && core_rst !== v; i++) cyc(1);
    if (core_rst !== v) begin
      err_total++;
      $display("mismatch core_rst exp %b got %b", v, core_rst);
      end_sim();
    end
  endtask : wrst
  // Bounded wait for a flag bit
  task wflg(input int b);
    for (int i = 0; i < 60 && flags[b] !== 1'b1; i++) cyc(1);
    chk("flag set", 16'h1, 16'(flags[b]));
    if (flags[b] !== 1'b1) end_sim();
  endtask : wflg
  // Vector to a source and check the address
  task ack(input logic [2:0] s);
    src = s;
    ack_v = 1;
    cyc(1);
    ack_v = 0;
    chk("pc_load", 16'h1, 16'(pc_load));
    chk("vector", 16'h0003 + 16'(s) * 16'h8, pc);
  endtask : ack
  // Reset state and loader strap
  task t_por;
    chk("pc", 16'h0, pc);
    chk("sp", 16'h7, 16'(sp));
    chk("port", 16'hFF, 16'(port));
    rst = 0;
    wrst(0);
    chk("app", 16'h0, 16'(app));
  endtask : t_por
  // Restart into the application store, then refusal
  task t_swrst;
    cwd = 8'h83;
    cwe = 1;
    cyc(1);
    cwe = 0;
    chk("sw rst", 16'h1, 16'({core_rst, app} == 2'b11));
    wrst(0);
    cwe = 1;
    cyc(1);
    cwe = 0;
    cyc(1);
    chk("no rst", 16'h83, 16'({core_rst, cc}));
  endtask : t_swrst
  // External edge and level requests
  task t_ext;
    e0 = 1;
    mwe = 1;
    ewd = 9'h1FF;
    ewe = 1;
    cyc(1);
    {mwe, ewe} = 2'b00;
    chk("en", 16'h1FF, 16'(en));
    rq = 4'h1;
    wflg(0);
    cyc(2);
    chk("req0", 16'h1, 16'(req[0]));
    ack(3'h0);
    chk("ext0 clr", 16'h0, 16'(flags[0]));
    rq = 4'h2;
    wflg(2);
    ack(3'h2);
    chk("ext1 kept", 16'h1, 16'(flags[2]));
    rq = 4'hC;
    wflg(9);
    chk("ext2 set", 16'h1, 16'(flags[8]));
    ack(3'h6);
    chk("ext2 kept", 16'h1, 16'(flags[8]));
    cyc(1);
    ack(3'h7);
    chk("ext3 kept", 16'h1, 16'(flags[9]));
    rq = 4'h0;
    cyc(40);
  endtask : t_ext
  // Event flags, hardware clearing on vectoring
  task t_evt(input int e, input int b, input logic [2:0] s, input logic k);
    ev[e] = 1;
    cyc(1);
    ev[e] = 0;
    ack(s);
    chk("evt flag", 16'(k), 16'(flags[b]));
  endtask : t_evt
  // Global mask over a software-set flag
  task t_mask;
    fwd = 10'h3FF;
    fwe = 1;
    ewd = 9'h0FF;
    ewe = 1;
    cyc(1);
    {fwe, ewe} = 2'b00;
    chk("flag wr", 16'h3FF, 16'(flags));
    cyc(2);
    chk("masked", 16'h0, 16'(req));
  endtask : t_mask
  // Pin reset clears enables and flags
  task t_pin;
    go = 1;
    cyc(1);
    go = 0;
    wrst(1);
    cyc(1);
    chk("pc", 16'h0, pc);
    wrst(0);
    chk("flags clear", 16'h0, 16'(flags));
    chk("en clear", 16'h0, 16'(en));
  endtask : t_pin
  // Watchdog time-out with reset
  task t_wdt;
    {wrun, wren, wwe} = 3'h7;
    cyc(1);
    wwe = 0;
    wrst(1);
    chk("wdt flag", 16'h1, 16'(wflag));
    wrst(0);
    wrst(1);
    wrst(0);
    {wrun, wren, wwe, wfc} = 4'h3;
    cyc(1);
    {wwe, wfc} = 2'b00;
    cyc(2);
    chk("wdt clr", 16'h0, 16'(wflag));
  endtask : t_wdt
  // Final counts and verdict
  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    cyc(12);
    t_por();
    t_swrst();
    t_ext();
    t_evt(0, 1, 3'h1, 0);
    t_evt(1, 3, 3'h3, 0);
    t_evt(3, 7, 3'h5, 1);
    t_evt(5, 5, 3'h4, 1);
    t_evt(2, 6, 3'h5, 1);
    t_evt(4, 4, 3'h4, 1);
    t_mask();
    t_pin();
    t_wdt();
    end_sim();
  end
endmodule : test_riv_reset_irq
